// File: logic/mcr_misc_control.sv
// miscellaneous control register with sample-ready pin, self-check and aux converter result
`timescale 1ns/1ns
`default_nettype none
`include "mcr_params.svh"

// What this block does
// - 16-bit misc_control at 0x34/0x35, resets 0x0000
// - default holds only until first write
// - sample-ready bits survive reset, nonvolatile
// - self-check bits 8/9 clear on every reset, bit 10 only on power-up clear
// - bit 10 skips startup self-check
// - startup self-check about 13/35 ms
// - bit 9 reverses inclination rotation
// - bit 8 runs continuous self-check
// - bit 2 enables, bit 0 picks pin
// - bit 1 sets sample-ready polarity
// - 12-bit converter result readable
// - result straight binary, zero-based
// - ready clears mid-conversion, sets after processing
// - misc over alarm over general pin setup
// - self-check forces 37 degrees, reports pass/fail
module mcr_misc_control
  import mcr_pkg::*;
#(
  parameter int POST_HP_CYC = `MCR_POST_HP_CYC,
  parameter int POST_LP_CYC = `MCR_POST_LP_CYC
) (
  input  wire logic                        clk,            // core clock, 20 MHz
  input  wire logic                        rst_n,          // synchronous reset, active low
  input  wire logic                        por_n,          // power-up clear, active low
  input  wire logic                        reg_wr,         // byte write strobe
  input  wire logic                        reg_rd,         // byte read strobe
  input  wire logic [`MCR_ADDR_W-1:0]      reg_addr,       // byte address
  input  wire logic [7:0]                  reg_wdata,      // write byte
  output logic      [7:0]                  reg_rdata_q,    // read byte
  input  wire logic                        low_power,      // low power mode
  input  wire logic                        sample_done,    // processing cycle complete
  input  wire logic                        conv_mid,       // partway through conversion
  input  wire logic                        check_pass,     // self-check diagnostic verdict
  input  wire logic [`MCR_INCL_W-1:0]      incl_raw,       // measured inclination
  input  wire logic                        adc_done,       // converter finished
  input  wire logic [`MCR_ADC_W-1:0]       adc_result,     // converter code
  input  wire mcr_pkg::mcr_pins_t          alarm_pins,     // alarm_setup pin claim
  input  wire logic [1:0]                  gpio_out,       // general pin levels
  input  wire logic [1:0]                  gpio_oe,        // general pin directions
  input  wire logic [1:0]                  aux_pin_in,     // aux pin levels from pads
  output logic      [1:0]                  aux_pin_out_q,  // aux pin drive level
  output logic      [1:0]                  aux_pin_oe_q,   // aux pin drive enable
  output logic      [1:0]                  aux_pin_level,  // synchronised pad level
  output logic      [`MCR_INCL_W-1:0]      incl_out_q,     // inclination presented
  output logic                             self_check_busy_q, // self-check running
  output logic                             self_check_fail_q  // last self-check failed
);

  // ****************************************************************
  // state
  // ****************************************************************
  mcr_vol_t                vol_q, vol_d;
  mcr_nvol_t               nvol_q, nvol_d;
  mcr_state_t              state_q, state_d;
  logic [`MCR_TMR_W-1:0]   tmr_q, tmr_d;
  logic                    fail_d;
  logic                    busy_d;
  logic                    rdy_act_q, rdy_act_d;
  logic [`MCR_ADC_W-1:0]   adc_q, adc_d;
  logic [7:0]              rdata_d;
  logic [15:0]             misc_word;
  logic [`MCR_INCL_W-1:0]  incl_d;
  mcr_pins_t               pins_d;
  logic                    rdy_level;

  // unused bit positions are never stored, so they read zero
  always_comb
  begin
    misc_word = `MCR_MISC_RESET;
    misc_word[`MCR_BIT_RDY_SEL] = nvol_q.rdy_sel;
    misc_word[`MCR_BIT_RDY_POL] = nvol_q.rdy_pol;
    misc_word[`MCR_BIT_RDY_EN]  = nvol_q.rdy_en;
    misc_word[`MCR_BIT_CHK_EN]  = vol_q.chk_en;
    misc_word[`MCR_BIT_REVERSE] = vol_q.reverse;
    misc_word[`MCR_BIT_NO_POST] = vol_q.no_post;
  end

  // ****************************************************************
  // register writes and reads
  // ****************************************************************
  always_comb
  begin
    vol_d  = vol_q;
    nvol_d = nvol_q;
    if (reg_wr && reg_addr == `MCR_ADDR_MISC_LO)
    begin
      nvol_d.rdy_sel = reg_wdata[`MCR_BIT_RDY_SEL];
      nvol_d.rdy_pol = reg_wdata[`MCR_BIT_RDY_POL];
      nvol_d.rdy_en  = reg_wdata[`MCR_BIT_RDY_EN];
    end
    if (reg_wr && reg_addr == `MCR_ADDR_MISC_HI)
    begin
      vol_d.chk_en  = reg_wdata[`MCR_BIT_CHK_EN - `MCR_HI_OFS];
      vol_d.reverse = reg_wdata[`MCR_BIT_REVERSE - `MCR_HI_OFS];
      vol_d.no_post = reg_wdata[`MCR_BIT_NO_POST - `MCR_HI_OFS];
    end
    adc_d = adc_done ? adc_result : adc_q;
    case (reg_addr)
      `MCR_ADDR_MISC_LO: rdata_d = misc_word[7:0];
      `MCR_ADDR_MISC_HI: rdata_d = misc_word[15:8];
      `MCR_ADDR_ADC_LO:  rdata_d = adc_q[7:0];
      `MCR_ADDR_ADC_HI:  rdata_d = {{(8-`MCR_ADC_HI_W){1'b0}}, adc_q[`MCR_ADC_W-1:8]};
      default:           rdata_d = `MCR_RDATA_NONE;
    endcase
    if (!reg_rd)
      rdata_d = reg_rdata_q;
  end

  always_ff @(posedge clk)
  begin
    // bit 10 outlives rst_n, else a skipped startup check could never be skipped
    if (!por_n)
    begin
      nvol_q        <= '0;
      vol_q.no_post <= 1'b0;
    end
    else
    begin
      nvol_q        <= nvol_d;
      vol_q.no_post <= vol_d.no_post;
    end
    if (!rst_n)
    begin
      vol_q.chk_en  <= 1'b0;
      vol_q.reverse <= 1'b0;
      adc_q         <= '0;
      reg_rdata_q   <= `MCR_RDATA_NONE;
    end
    else
    begin
      vol_q.chk_en  <= vol_d.chk_en;
      vol_q.reverse <= vol_d.reverse;
      adc_q         <= adc_d;
      reg_rdata_q   <= rdata_d;
    end
  end

  // ****************************************************************
  // self-check sequencer
  // ****************************************************************
  always_comb
  begin
    state_d = state_q;
    tmr_d   = tmr_q;
    fail_d  = self_check_fail_q;
    case (state_q)
      MCR_SEQ_BOOT:
      begin
        if (vol_q.no_post)
          state_d = MCR_SEQ_IDLE;
        else
        begin
          state_d = MCR_SEQ_POST;
          tmr_d   = low_power ? `MCR_TMR_W'(POST_LP_CYC - 1)
                              : `MCR_TMR_W'(POST_HP_CYC - 1);
        end
      end
      MCR_SEQ_POST:
      begin
        if (tmr_q == `MCR_TMR_ZERO)
        begin
          state_d = MCR_SEQ_IDLE;
          fail_d  = !check_pass;
        end
        else
          tmr_d = tmr_q - `MCR_TMR_ONE;
      end
      MCR_SEQ_IDLE:
      begin
        if (vol_q.chk_en)
          state_d = MCR_SEQ_CONT;
      end
      MCR_SEQ_CONT:
      begin
        fail_d = !check_pass;
        if (!vol_q.chk_en)
          state_d = MCR_SEQ_IDLE;
      end
      default: state_d = MCR_SEQ_IDLE;
    endcase
    busy_d = (state_d == MCR_SEQ_POST) || (state_d == MCR_SEQ_CONT);
    if (busy_d)
      incl_d = `MCR_INCL_NOMINAL;
    else if (vol_d.reverse && incl_raw != `MCR_INCL_ZERO)
      incl_d = `MCR_INCL_FULL - incl_raw;
    else
      incl_d = incl_raw;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      state_q           <= MCR_SEQ_BOOT;
      tmr_q             <= `MCR_TMR_ZERO;
      self_check_fail_q <= 1'b0;
      self_check_busy_q <= 1'b0;
      incl_out_q        <= `MCR_INCL_ZERO;
    end
    else
    begin
      state_q           <= state_d;
      tmr_q             <= tmr_d;
      self_check_fail_q <= fail_d;
      self_check_busy_q <= busy_d;
      incl_out_q        <= incl_d;
    end
  end

  // ****************************************************************
  // sample-ready output and aux pin arbitration
  // ****************************************************************
  always_comb
  begin
    rdy_act_d = rdy_act_q;
    if (conv_mid)
      rdy_act_d = 1'b0;
    if (sample_done)
      rdy_act_d = 1'b1;
    rdy_level = nvol_d.rdy_pol ? rdy_act_d : !rdy_act_d;
    pins_d.out = gpio_out;
    pins_d.oe  = gpio_oe;
    for (int i = 0; i < 2; i++)
    begin
      if (alarm_pins.oe[i])
      begin
        pins_d.out[i] = alarm_pins.out[i];
        pins_d.oe[i]  = 1'b1;
      end
      if (nvol_d.rdy_en && (nvol_d.rdy_sel == i[0]))
      begin
        pins_d.out[i] = rdy_level;
        pins_d.oe[i]  = 1'b1;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      rdy_act_q     <= 1'b0;
      aux_pin_out_q <= 2'h0;
      aux_pin_oe_q  <= 2'h0;
    end
    else
    begin
      rdy_act_q     <= rdy_act_d;
      aux_pin_out_q <= pins_d.out;
      aux_pin_oe_q  <= pins_d.oe;
    end
  end

  mcr_sync3 #(
    .WIDTH   (2)
  ) u_pin_sync (
    .clk     (clk),
    .rst_n   (rst_n),
    .async_i (aux_pin_in),
    .level_q (aux_pin_level)
  );

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_ready_set;
    sample_done ##1 rdy_act_q;
  endsequence

  sequence s_post_start;
    state_q == MCR_SEQ_BOOT && !vol_q.no_post && !low_power;
  endsequence

  a_unused_zero: assert property (misc_word[15:11] == 5'h00 && misc_word[7:3] == 5'h00)
    else $error("unused misc_control bits not zero");
  a_vol_clear: assert property (disable iff (1'b0) !rst_n |=> !vol_q.chk_en && !vol_q.reverse)
    else $error("self-check bits survived reset");
  a_skip_keep: assert property (disable iff (1'b0) !rst_n && por_n
                                |=> vol_q.no_post == $past(vol_q.no_post))
    else $error("startup skip bit lost over reset");
  a_nvol_keep: assert property (disable iff (1'b0) !rst_n && por_n |=> nvol_q == $past(nvol_q))
    else $error("sample-ready bits lost over reset");
  a_post_load: assert property (s_post_start |=> tmr_q == `MCR_TMR_W'(POST_HP_CYC - 1))
    else $error("startup self-check length wrong");
  a_post_skip: assert property (state_q == MCR_SEQ_BOOT && vol_q.no_post |=> !self_check_busy_q)
    else $error("startup self-check not skipped");
  a_post_end: assert property (state_q == MCR_SEQ_POST && tmr_q == `MCR_TMR_ZERO
                               |=> state_q == MCR_SEQ_IDLE
                               && self_check_fail_q == !$past(check_pass))
    else $error("startup self-check end wrong");
  a_cont_run: assert property (state_q == MCR_SEQ_IDLE && vol_q.chk_en |=> self_check_busy_q)
    else $error("continuous self-check not started");
  a_incl_nominal: assert property (self_check_busy_q |-> incl_out_q == `MCR_INCL_NOMINAL)
    else $error("inclination not nominal during self-check");
  a_incl_reverse: assert property (!busy_d && vol_d.reverse && incl_raw != `MCR_INCL_ZERO
                                   |=> incl_out_q == `MCR_INCL_FULL - $past(incl_raw))
    else $error("reverse rotation wrong");
  a_ready_set: assert property (sample_done |-> s_ready_set)
    else $error("sample-ready not set");
  a_ready_clear: assert property (conv_mid && !sample_done |=> !rdy_act_q)
    else $error("sample-ready not cleared");
  a_ready_pin: assert property (nvol_q.rdy_en && $past(rst_n) |-> aux_pin_oe_q[nvol_q.rdy_sel]
                                && aux_pin_out_q[nvol_q.rdy_sel]
                                == (nvol_q.rdy_pol ~^ rdy_act_q))
    else $error("sample-ready pin drive wrong");
  a_adc_capture: assert property (adc_done |=> adc_q == $past(adc_result))
    else $error("converter result not captured");

endmodule : mcr_misc_control

`default_nettype wire

// File: logic/mcr_params.svh
// constants of the miscellaneous control block
`ifndef MCR_PARAMS_SVH
`define MCR_PARAMS_SVH

// ****************************************************************
// register map (byte addresses of the register port)
// ****************************************************************
`define MCR_ADDR_W          6
`define MCR_ADDR_MISC_LO    6'h34
`define MCR_ADDR_MISC_HI    6'h35
`define MCR_ADDR_ADC_LO     6'h0A
`define MCR_ADDR_ADC_HI     6'h0B
`define MCR_MISC_RESET      16'h0000
`define MCR_RDATA_NONE      8'h00

// ****************************************************************
// field positions inside misc_control
// ****************************************************************
`define MCR_BIT_RDY_SEL     0
`define MCR_BIT_RDY_POL     1
`define MCR_BIT_RDY_EN      2
`define MCR_BIT_CHK_EN      8
`define MCR_BIT_REVERSE     9
`define MCR_BIT_NO_POST     10
`define MCR_HI_OFS          8

// ****************************************************************
// converter and angle figures
// ****************************************************************
`define MCR_ADC_W           12
`define MCR_ADC_HI_W        4
`define MCR_INCL_W          14
`define MCR_INCL_FULL       14'h3840
`define MCR_INCL_NOMINAL    14'h05C8
`define MCR_INCL_ZERO       14'h0000

// ****************************************************************
// timing
// ****************************************************************
`define MCR_CLK_HZ          20000000
`define MCR_POST_HP_MS      13
`define MCR_POST_LP_MS      35
`define MCR_POST_HP_CYC     (`MCR_POST_HP_MS * (`MCR_CLK_HZ / 1000))
`define MCR_POST_LP_CYC     (`MCR_POST_LP_MS * (`MCR_CLK_HZ / 1000))
`define MCR_TMR_W           20
`define MCR_TMR_ZERO        20'h00000
`define MCR_TMR_ONE         20'h00001

`endif

// File: logic/mcr_pkg.sv
// types shared by the miscellaneous control block
`default_nettype none
package mcr_pkg;

  // ****************************************************************
  // register fields and pin drive bundles
  // ****************************************************************
  typedef struct packed {
    logic no_post;
    logic reverse;
    logic chk_en;
  } mcr_vol_t;

  typedef struct packed {
    logic rdy_en;
    logic rdy_pol;
    logic rdy_sel;
  } mcr_nvol_t;

  typedef struct packed {
    logic [1:0] out;
    logic [1:0] oe;
  } mcr_pins_t;

  typedef enum logic [1:0] {
    MCR_SEQ_BOOT,
    MCR_SEQ_POST,
    MCR_SEQ_IDLE,
    MCR_SEQ_CONT
  } mcr_state_t;

endpackage : mcr_pkg

`default_nettype wire

// File: logic/mcr_sync3.sv
// three-stage synchroniser that accepts a change once stages two and three agree
`timescale 1ns/1ns
`default_nettype none

module mcr_sync3 #(
  parameter int WIDTH = 2
) (
  input  wire logic             clk,     // core clock
  input  wire logic             rst_n,   // synchronous reset, active low
  input  wire logic [WIDTH-1:0] async_i, // level from outside the domain
  output logic      [WIDTH-1:0] level_q  // filtered level
);

  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;
  logic [WIDTH-1:0] level_d;

  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++)
    begin : g_bit
      always_comb
      begin
        level_d[gi] = (s2_q[gi] == s3_q[gi]) ? s3_q[gi] : level_q[gi];
      end

      always_ff @(posedge clk)
      begin
        if (!rst_n)
        begin
          s1_q[gi]    <= 1'b0;
          s2_q[gi]    <= 1'b0;
          s3_q[gi]    <= 1'b0;
          level_q[gi] <= 1'b0;
        end
        else
        begin
          s1_q[gi]    <= async_i[gi];
          s2_q[gi]    <= s1_q[gi];
          s3_q[gi]    <= s2_q[gi];
          level_q[gi] <= level_d[gi];
        end
      end
    end
  endgenerate

endmodule : mcr_sync3

`default_nettype wire

// File: tb/mcr_host_model.sv
// host model that drives the byte register port
`timescale 1ns/1ns
`default_nettype none

module mcr_host_model (
  input  wire logic       clk,   // core clock
  output logic            wr,    // write strobe
  output logic            rd,    // read strobe
  output logic [5:0]      addr,  // byte address
  output logic [7:0]      wdata, // write byte
  input  wire logic [7:0] rdata  // read byte
);
  // ****************************************************************
  // one-cycle byte transfers, released lines show the inverse
  // ****************************************************************
  initial
  begin
    wr    = 1'b0;
    rd    = 1'b0;
    addr  = 6'h00;
    wdata = 8'h00;
  end

  task automatic put(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk);
    #5;
    wr    = 1'b1;
    addr  = a;
    wdata = d;
    @(posedge clk);
    #5;
    wr    = 1'b0;
    addr  = ~a;
    wdata = ~d;
  endtask : put

  task automatic get(input logic [5:0] a, output logic [7:0] d);
    @(posedge clk);
    #5;
    rd   = 1'b1;
    addr = a;
    @(posedge clk);
    #5;
    rd   = 1'b0;
    addr = ~a;
    d    = rdata;
  endtask : get
endmodule : mcr_host_model
`default_nettype wire

// File: tb/tb_misc_control_ready_selftest.sv
// self-checking bench for the miscellaneous control block
`timescale 1ns/1ns
`default_nettype none
`include "mcr_params.svh"

module tb_misc_control_ready_selftest;
  import mcr_pkg::*;
  localparam int HP = 20;
  localparam int LP = 40;
  logic clk, rst_n, por_n, low_power, sample_done, conv_mid, check_pass, adc_done;
  logic reg_wr, reg_rd, busy, fail;
  logic [5:0]  reg_addr;
  logic [7:0]  reg_wdata, reg_rdata_q, rd_v;
  logic [13:0] incl_raw, incl_out_q;
  logic [11:0] adc_result;
  logic [1:0]  gpio_out, gpio_oe, aux_pin_in, aux_pin_out_q, aux_pin_oe_q, aux_pin_level;
  mcr_pins_t   alarm_pins;
  int error_cnt = 0;
  int n_tests = 0;
  int m_reg = 0;
  int ready = 0;
  int q_adc[$];

  // ****************************************************************
  // clock, design and host
  // ****************************************************************
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  mcr_misc_control #(.POST_HP_CYC(HP), .POST_LP_CYC(LP)) u_dut (
    .clk(clk), .rst_n(rst_n), .por_n(por_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q),
    .low_power(low_power), .sample_done(sample_done), .conv_mid(conv_mid),
    .check_pass(check_pass), .incl_raw(incl_raw), .adc_done(adc_done),
    .adc_result(adc_result), .alarm_pins(alarm_pins), .gpio_out(gpio_out),
    .gpio_oe(gpio_oe), .aux_pin_in(aux_pin_in), .aux_pin_out_q(aux_pin_out_q),
    .aux_pin_oe_q(aux_pin_oe_q), .aux_pin_level(aux_pin_level),
    .incl_out_q(incl_out_q), .self_check_busy_q(busy), .self_check_fail_q(fail));

  mcr_host_model u_host (.clk(clk), .wr(reg_wr), .rd(reg_rd), .addr(reg_addr),
    .wdata(reg_wdata), .rdata(reg_rdata_q));

  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : stop_test

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #5;
  endtask : cyc

  task automatic wreg(input logic [5:0] a, input logic [7:0] d);
    u_host.put(a, d);
    if (a == `MCR_ADDR_MISC_LO)
      m_reg = (m_reg & 32'hFF00) | int'(d & 8'h07);
    if (a == `MCR_ADDR_MISC_HI)
      m_reg = (m_reg & 32'h00FF) | (int'(d & 8'h07) << 8);
  endtask : wreg

  task automatic rreg(input logic [5:0] a, input logic [7:0] e);
    u_host.get(a, rd_v);
    chk({8'h00, rd_v}, {8'h00, e});
  endtask : rreg

  task automatic do_reset(input logic por);
    rst_n = 1'b0;
    por_n = ~por;
    cyc(3);
    rst_n = 1'b1;
    por_n = 1'b1;
    m_reg = por ? 0 : (m_reg & 32'h0407);
  endtask : do_reset

  task automatic post(input int n);
    int w = 0;
    int c = 0;
    while (busy !== 1'b1 && w < 10)
    begin
      cyc(1);
      w++;
    end
    chk({15'h0, busy}, 16'h0001);
    chk({2'b0, incl_out_q}, {2'b0, `MCR_INCL_NOMINAL});
    while (busy === 1'b1 && c < 2 * n)
    begin
      cyc(1);
      c++;
    end
    chk({15'h0, c >= n - 1 && c <= n + 1}, 16'h0001);
  endtask : post

  task automatic pins();
    logic [1:0] ee, eo;
    for (int i = 0; i < 2; i++)
      if (m_reg[2] && m_reg[0] == i)
      begin
        ee[i] = 1'b1;
        eo[i] = ready ? m_reg[1] : !m_reg[1];
      end
      else if (alarm_pins.oe[i])
      begin
        ee[i] = 1'b1;
        eo[i] = alarm_pins.out[i];
      end
      else
      begin
        ee[i] = gpio_oe[i];
        eo[i] = gpio_out[i];
      end
    chk({12'h0, aux_pin_oe_q, aux_pin_out_q & aux_pin_oe_q}, {12'h0, ee, eo & ee});
  endtask : pins

  task automatic ev(input logic s, input logic c);
    sample_done = s;
    conv_mid = c;
    cyc(1);
    sample_done = 1'b0;
    conv_mid = 1'b0;
    if (s)
      ready = 1;
    else if (c)
      ready = 0;
    cyc(2);
    pins();
  endtask : ev

  // ****************************************************************
  // scenarios
  // ****************************************************************
  initial
  begin
    void'($urandom(32'h22697443));
    {low_power, sample_done, conv_mid, adc_done, adc_result} = '0;
    {alarm_pins, gpio_out, gpio_oe} = '0;
    check_pass = 1'b1;
    incl_raw = 14'd100;
    aux_pin_in = 2'($urandom);
    do_reset(1'b1);
    post(HP);
    rreg(`MCR_ADDR_MISC_LO, 8'h00);
    rreg(`MCR_ADDR_MISC_HI, 8'h00);
    wreg(`MCR_ADDR_MISC_LO, 8'($urandom) | 8'hF8);
    rreg(`MCR_ADDR_MISC_LO, 8'(m_reg));
    wreg(`MCR_ADDR_MISC_HI, 8'hF8);
    rreg(`MCR_ADDR_MISC_HI, 8'h00);
    rreg(6'h20, 8'h00);
    for (int k = 0; k < 8; k++)
    begin
      wreg(`MCR_ADDR_MISC_LO, 8'(k));
      alarm_pins = 4'($urandom);
      {gpio_out, gpio_oe} = 4'($urandom);
      ev(1'b0, 1'b1);
      ev(1'b1, 1'b0);
      ev(1'b0, 1'b1);
      ev(1'b1, 1'b1);
    end
    wreg(`MCR_ADDR_MISC_HI, 8'h02);
    for (int k = 0; k < 5; k++)
    begin
      incl_raw = (k == 0) ? 14'd0 : 14'($urandom % 14400);
      cyc(3);
      chk({2'b0, incl_out_q}, 16'((incl_raw == 0) ? 0 : 14400 - int'(incl_raw)));
    end
    wreg(`MCR_ADDR_MISC_HI, 8'h00);
    cyc(3);
    chk({2'b0, incl_out_q}, {2'b0, incl_raw});
    wreg(`MCR_ADDR_MISC_HI, 8'h01);
    cyc(3);
    chk({15'h0, busy}, 16'h0001);
    chk({2'b0, incl_out_q}, {2'b0, `MCR_INCL_NOMINAL});
    check_pass = 1'b0;
    cyc(3);
    chk({15'h0, fail}, 16'h0001);
    check_pass = 1'b1;
    cyc(3);
    chk({15'h0, fail}, 16'h0000);
    wreg(`MCR_ADDR_MISC_HI, 8'h00);
    cyc(3);
    chk({15'h0, busy}, 16'h0000);
    wreg(`MCR_ADDR_MISC_LO, 8'h05);
    wreg(`MCR_ADDR_MISC_HI, 8'h02);
    do_reset(1'b0);
    low_power = 1'b1;
    post(LP);
    rreg(`MCR_ADDR_MISC_LO, 8'h05);
    rreg(`MCR_ADDR_MISC_HI, 8'h00);
    for (int k = 0; k < 3; k++)
    begin
      adc_result = 12'($urandom);
      q_adc.push_back(int'(adc_result));
      adc_done = 1'b1;
      cyc(1);
      adc_done = 1'b0;
      cyc(2);
      rreg(`MCR_ADDR_ADC_LO, 8'(q_adc[0]));
      rreg(`MCR_ADDR_ADC_HI, 8'(q_adc.pop_front() >> 8));
    end
    wreg(`MCR_ADDR_MISC_HI, 8'h04);
    do_reset(1'b0);
    aux_pin_in = 2'($urandom);
    cyc(4);
    chk({15'h0, busy}, 16'h0000);
    chk({14'h0, aux_pin_level}, {14'h0, aux_pin_in});
    rreg(`MCR_ADDR_MISC_HI, 8'(m_reg >> 8));
    stop_test();
  end

  initial
  begin
    #500000;
    error_cnt++;
    stop_test();
  end
endmodule : tb_misc_control_ready_selftest
`default_nettype wire
